// >>> inc/snva_pkg.sv
package snva_pkg;

    // Array geometry
    localparam int ADDR_W = 15;
    localparam int ROW_W = 12;
    localparam int COL_W = 3;
    localparam int ROW_BITS = 64;
    localparam int ROWS = 4096;

    // Command codes
    localparam logic [7:0] OPC_SET_LATCH = 8'h06;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;

    // Address landmarks
    localparam logic [14:0] ADDR_TOP = 15'h7FFF;
    localparam logic [14:0] ADDR_ZERO = 15'h0000;
    localparam logic [14:0] ADDR_STEP = 15'h0001;
    localparam logic [14:0] GUARD_QTR_BASE = 15'h6000;
    localparam logic [14:0] GUARD_HALF_BASE = 15'h4000;

    // Block guard settings {hi, lo}
    localparam logic [1:0] GUARD_NONE = 2'h0;
    localparam logic [1:0] GUARD_QTR = 2'h1;
    localparam logic [1:0] GUARD_HALF = 2'h2;
    localparam logic [1:0] GUARD_ALL = 2'h3;

    // Bit counting within a byte
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;

    // Positions in the filtered pin vector
    localparam int PIN_CS = 0;
    localparam int PIN_WP = 1;
    localparam int PIN_GUARD_HI = 2;
    localparam int PIN_GUARD_LO = 3;
    localparam int PIN_N = 4;

    // Values after reset
    localparam logic [3:0] PINS_RESET = 4'h3;
    localparam logic LATCH_RESET = 1'b0;
    localparam logic ALLOW_RESET = 1'b0;
    localparam logic [1:0] GUARD_RESET = 2'h3;

    // Transaction phases, Gray coded along the usual path
    typedef enum logic [2:0] {
        PH_OPCODE = 3'b000,
        PH_ADDR_HI = 3'b001,
        PH_ADDR_LO = 3'b011,
        PH_READ = 3'b010,
        PH_WRITE = 3'b111,
        PH_SKIP = 3'b110
    } snva_phase_t;

endpackage

// >>> inc/snva_row_if.sv
`timescale 1ns/1ps
interface snva_row_if;
    logic [11:0] row_idx;
    logic [63:0] row_data;
    logic wr_en;
    logic [2:0] wr_col;
    logic [7:0] wr_byte;

    modport engine (output row_idx, output wr_en, output wr_col, output wr_byte, input row_data);
    modport store (input row_idx, input wr_en, input wr_col, input wr_byte, output row_data);
endinterface

// >>> design/snva_row_store.sv
`timescale 1ns/1ps
module snva_row_store (
    input wire logic clk_in,          // Link clock
    snva_row_if.store row_bus         // Row access from the engine
);
    logic [63:0] mem [snva_pkg::ROWS];

    // Whole row is presented at once
    assign row_bus.row_data = mem[row_bus.row_idx];

    // Byte write into the open row
    always_ff @(posedge clk_in) begin
        if (row_bus.wr_en) begin
            mem[row_bus.row_idx][{row_bus.wr_col, 3'h0} +: 8] <= row_bus.wr_byte;
        end
    end
endmodule

// >>> design/snva_nvram_access.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Write needs earlier enable frame, then write
// - Address top bit dropped, low 15 used
// - Address steps per byte, wraps to zero
// - All bytes travel MSB first
// - Byte stored right after eighth bit, unlimited
// - Chip select high ends write transaction
// - Protect pin sampled only at select fall
// - Read opcode then two address bytes
// - Serial input ignored after read address
// - Eight clocks per read byte, continuing
// - Chip select high ends read, releases output
// - Pause low with clock low suspends
// - Pause high with clock low resumes
// - Clocks during pause change nothing
// - Rows A14-A3, columns A2-A0, one opening
// - Command codes 06h, 03h, 02h
// - Input on rising, output on falling edge
// - Write completion clears latch; latch needed
// - Guarded block range never written
module snva_nvram_access (
    input wire logic clk_sys_in,          // System clock, 100 MHz
    input wire logic reset_n_in,          // Reset, active low; synchronous for system side state, asynchronous for the link event toggles
    input wire logic sck_in,              // Serial clock from master
    input wire logic cs_n_in,             // Chip select, active low
    input wire logic si_in,               // Serial data in
    input wire logic hold_n_in,           // Pause, active low
    input wire logic wp_n_in,             // Write protect, active low
    input wire logic block_guard_hi_in,   // Block guard upper bit
    input wire logic block_guard_lo_in,   // Block guard lower bit
    output logic so_out,                  // Serial data out
    output logic so_oe_out,               // Output enable for data out
    output logic write_latch_flag_out     // Write latch state
);
    // System side state
    typedef struct packed {
        logic [3:0] pin_s0;
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [3:0] pin_lvl;
        logic [1:0] set_write_latch_cmd_sy;
        logic set_write_latch_cmd_seen;
        logic [1:0] wr_sy;
        logic wr_seen;
        logic latch;
        logic wr_pending;
        logic allow;
        logic [1:0] guard;
    } snva_sys_t;

    // Link side state that lives for one frame
    typedef struct packed {
        snva_pkg::snva_phase_t phase;
        logic [2:0] bit_cnt;
        logic [6:0] shift;
        logic [14:0] addr;
        logic is_write;
        logic [63:0] row_buf;
        logic [2:0] cfg_s0;
        logic [2:0] cfg_s1;
    } snva_lnk_t;

    // Link side events that outlive the frame
    typedef struct packed {
        logic set_write_latch_cmd_tog;
        logic wr_tog;
    } snva_evt_t;

    // Falling edge output stage
    typedef struct packed {
        logic so;
        logic oe;
    } snva_out_t;

    snva_sys_t sy_q;
    snva_sys_t sy_d;
    snva_lnk_t ln_q;
    snva_lnk_t ln_d;
    snva_evt_t ev_q;
    snva_evt_t ev_d;
    snva_out_t out_q;
    snva_out_t out_d;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic wr_fire;
    logic set_write_latch_cmd_evt;
    logic wr_evt;
    logic cs_rise;
    logic cs_fall;
    logic allow_lnk;
    logic [1:0] guard_lnk;
    snva_row_if row_bus ();

    // True when the address sits in the guarded block range
    function automatic logic guarded(input logic [14:0] a, input logic [1:0] g);
        logic hit;
        hit = 1'b0;
        case (g)
            snva_pkg::GUARD_NONE: hit = 1'b0;
            snva_pkg::GUARD_QTR: hit = (a >= snva_pkg::GUARD_QTR_BASE);
            snva_pkg::GUARD_HALF: hit = (a >= snva_pkg::GUARD_HALF_BASE);
            snva_pkg::GUARD_ALL: hit = 1'b1;
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

    // System domain events
    assign set_write_latch_cmd_evt = sy_q.set_write_latch_cmd_sy[1] ^ sy_q.set_write_latch_cmd_seen;
    assign wr_evt = sy_q.wr_sy[1] ^ sy_q.wr_seen;
    assign cs_rise = sy_q.pin_s1[snva_pkg::PIN_CS] & sy_q.pin_s2[snva_pkg::PIN_CS] & ~sy_q.pin_lvl[snva_pkg::PIN_CS];
    assign cs_fall = ~sy_q.pin_s1[snva_pkg::PIN_CS] & ~sy_q.pin_s2[snva_pkg::PIN_CS] & sy_q.pin_lvl[snva_pkg::PIN_CS];

    // Pin filters, write latch and per-frame write permission
    always_comb begin
        sy_d = sy_q;
        sy_d.pin_s0 = {block_guard_lo_in, block_guard_hi_in, wp_n_in, cs_n_in};
        sy_d.pin_s1 = sy_q.pin_s0;
        sy_d.pin_s2 = sy_q.pin_s1;
        for (int i = 0; i < snva_pkg::PIN_N; i++) begin
            if (sy_q.pin_s1[i] == sy_q.pin_s2[i]) begin
                sy_d.pin_lvl[i] = sy_q.pin_s2[i];
            end
        end
        sy_d.set_write_latch_cmd_sy = {sy_q.set_write_latch_cmd_sy[0], ev_q.set_write_latch_cmd_tog};
        sy_d.set_write_latch_cmd_seen = sy_q.set_write_latch_cmd_sy[1];
        sy_d.wr_sy = {sy_q.wr_sy[0], ev_q.wr_tog};
        sy_d.wr_seen = sy_q.wr_sy[1];
        if (wr_evt) begin
            sy_d.wr_pending = 1'b1;
        end
        if (cs_rise && (sy_q.wr_pending || wr_evt)) begin
            sy_d.latch = 1'b0;
            sy_d.wr_pending = 1'b0;
        end
        if (set_write_latch_cmd_evt) begin
            sy_d.latch = 1'b1;
        end
        if (cs_fall) begin
            sy_d.allow = sy_q.latch & sy_q.pin_lvl[snva_pkg::PIN_WP];
            sy_d.guard = {sy_q.pin_lvl[snva_pkg::PIN_GUARD_HI], sy_q.pin_lvl[snva_pkg::PIN_GUARD_LO]};
        end
    end

    // System domain register
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            sy_q <= '0;
            sy_q.pin_s0 <= snva_pkg::PINS_RESET;
            sy_q.pin_s1 <= snva_pkg::PINS_RESET;
            sy_q.pin_s2 <= snva_pkg::PINS_RESET;
            sy_q.pin_lvl <= snva_pkg::PINS_RESET;
            sy_q.latch <= snva_pkg::LATCH_RESET;
            sy_q.allow <= snva_pkg::ALLOW_RESET;
            sy_q.guard <= snva_pkg::GUARD_RESET;
        end else begin
            sy_q <= sy_d;
        end
    end

    // Frame-stable settings as seen from the link side
    assign allow_lnk = ln_q.cfg_s1[2];
    assign guard_lnk = ln_q.cfg_s1[1:0];
    assign byte_in = {ln_q.shift, si_in};
    assign rd_byte = ln_q.row_buf[{ln_q.addr[2:0], 3'h0} +: 8];

    // Serial engine: opcode, address, data
    always_comb begin
        ln_d = ln_q;
        ev_d = ev_q;
        wr_fire = 1'b0;
        ln_d.cfg_s0 = {sy_q.allow, sy_q.guard};
        ln_d.cfg_s1 = ln_q.cfg_s0;
        if (hold_n_in) begin
            ln_d.shift = byte_in[6:0];
            ln_d.bit_cnt = ln_q.bit_cnt + snva_pkg::BIT_STEP;
            if (ln_q.bit_cnt == snva_pkg::BIT_LAST) begin
                case (ln_q.phase)
                    snva_pkg::PH_OPCODE: begin
                        case (byte_in)
                            snva_pkg::OPC_SET_LATCH: begin
                                ev_d.set_write_latch_cmd_tog = ~ev_q.set_write_latch_cmd_tog;
                                ln_d.phase = snva_pkg::PH_SKIP;
                            end
                            snva_pkg::OPC_READ: begin
                                ln_d.is_write = 1'b0;
                                ln_d.phase = snva_pkg::PH_ADDR_HI;
                            end
                            snva_pkg::OPC_WRITE: begin
                                ln_d.is_write = 1'b1;
                                ev_d.wr_tog = ~ev_q.wr_tog;
                                ln_d.phase = snva_pkg::PH_ADDR_HI;
                            end
                            default: begin
                                ln_d.phase = snva_pkg::PH_SKIP;
                            end
                        endcase
                    end
                    snva_pkg::PH_ADDR_HI: begin
                        ln_d.addr[14:8] = byte_in[6:0];
                        ln_d.phase = snva_pkg::PH_ADDR_LO;
                    end
                    snva_pkg::PH_ADDR_LO: begin
                        ln_d.addr[7:0] = byte_in;
                        ln_d.row_buf = row_bus.row_data;
                        ln_d.phase = ln_q.is_write ? snva_pkg::PH_WRITE : snva_pkg::PH_READ;
                    end
                    snva_pkg::PH_READ: begin
                        ln_d.addr = ln_q.addr + snva_pkg::ADDR_STEP;
                        if (ln_q.addr[2:0] == snva_pkg::BIT_LAST) begin
                            ln_d.row_buf = row_bus.row_data;
                        end
                    end
                    snva_pkg::PH_WRITE: begin
                        wr_fire = allow_lnk && !guarded(ln_q.addr, guard_lnk);
                        ln_d.addr = ln_q.addr + snva_pkg::ADDR_STEP;
                    end
                    snva_pkg::PH_SKIP: begin
                        ln_d.phase = snva_pkg::PH_SKIP;
                    end
                    default: begin
                        ln_d.phase = snva_pkg::PH_SKIP;
                    end
                endcase
            end
        end
    end

    // Row port toward the array: new start row, next row at a read row edge, else the current one
    assign row_bus.row_idx = (!hold_n_in || ln_q.bit_cnt != snva_pkg::BIT_LAST) ? ln_q.addr[14:3]
        : (ln_q.phase == snva_pkg::PH_ADDR_LO) ? {ln_q.addr[14:8], byte_in[7:3]}
        : (ln_q.phase == snva_pkg::PH_READ && ln_q.addr[2:0] == snva_pkg::BIT_LAST) ? ln_q.addr[14:3] + 12'h001
        : ln_q.addr[14:3];
    assign row_bus.wr_en = wr_fire;
    assign row_bus.wr_col = ln_q.addr[2:0];
    assign row_bus.wr_byte = byte_in;

    // Frame state; chip select high drops any partial byte
    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            ln_q <= '0;
        end else begin
            ln_q <= ln_d;
        end
    end

    // Event toggles that cross to the system side
    always_ff @(posedge sck_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ev_q <= '0;
        end else begin
            ev_q <= ev_d;
        end
    end

    // Read data, one bit per falling edge, MSB first
    always_comb begin
        out_d = out_q;
        out_d.oe = 1'b0;
        if (!hold_n_in) begin
            out_d.oe = 1'b0;
        end else if (ln_q.phase == snva_pkg::PH_READ) begin
            out_d.oe = 1'b1;
            out_d.so = rd_byte[snva_pkg::BIT_LAST - ln_q.bit_cnt];
        end
    end

    // Output stage; chip select high releases the pin
    always_ff @(negedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign so_out = out_q.so;
    assign so_oe_out = out_q.oe;
    assign write_latch_flag_out = sy_q.latch;

    snva_row_store u_store (
        .clk_in(sck_in),
        .row_bus(row_bus.store)
    );

    // Byte boundaries on the link
    sequence rd_byte_done;
        ln_q.phase == snva_pkg::PH_READ && ln_q.bit_cnt == snva_pkg::BIT_LAST && hold_n_in;
    endsequence

    sequence addr_hi_done;
        ln_q.phase == snva_pkg::PH_ADDR_HI && ln_q.bit_cnt == snva_pkg::BIT_LAST && hold_n_in;
    endsequence

    AST_RD_WRAP: assert property (@(posedge sck_in) disable iff (cs_n_in)
        (rd_byte_done ##0 ln_q.addr == snva_pkg::ADDR_TOP) |=> ln_q.addr == snva_pkg::ADDR_ZERO)
        else $error("read address did not wrap to zero");

    AST_ADDR_TOP_DROP: assert property (@(posedge sck_in) disable iff (cs_n_in)
        addr_hi_done |=> ln_q.addr[14:8] == {$past(ln_q.shift[5:0]), $past(si_in)})
        else $error("upper address byte not taken as seven bits");

    AST_COMMIT_EIGHTH: assert property (@(posedge sck_in) disable iff (cs_n_in)
        row_bus.wr_en |-> ln_q.phase == snva_pkg::PH_WRITE && ln_q.bit_cnt == snva_pkg::BIT_LAST)
        else $error("array write outside eighth bit of a data byte");

    AST_GUARDED: assert property (@(posedge sck_in) disable iff (cs_n_in)
        row_bus.wr_en |-> !guarded(ln_q.addr, guard_lnk))
        else $error("write into guarded block");

    AST_NEED_LATCH: assert property (@(posedge sck_in) disable iff (cs_n_in)
        row_bus.wr_en |-> allow_lnk)
        else $error("write without latch or with protect low");

    AST_HOLD_FREEZE: assert property (@(posedge sck_in) disable iff (cs_n_in)
        !hold_n_in |=> ln_q.addr == $past(ln_q.addr) && ln_q.bit_cnt == $past(ln_q.bit_cnt)
            && ln_q.phase == $past(ln_q.phase))
        else $error("transaction moved during pause");

    AST_OE_OFF: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        cs_n_in |-> !so_oe_out)
        else $error("data out driven while deselected");

    AST_LATCH_CLR: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (cs_rise && (sy_q.wr_pending || wr_evt) && !set_write_latch_cmd_evt) |=> !write_latch_flag_out)
        else $error("latch not cleared after write frame");

    AST_SET_WRITE_LATCH_CMD_SET: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        set_write_latch_cmd_evt |=> write_latch_flag_out)
        else $error("enable command did not set latch");

    AST_WP_FROZEN: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        !cs_fall |=> $stable(sy_q.allow))
        else $error("write permission changed inside a frame");

endmodule

// >>> tb/snva_spi_master.sv
`timescale 1ns/1ps
module snva_spi_master (
    output logic sck_out,       // Serial clock, idle low
    output logic cs_n_out,      // Chip select, active low
    output logic si_out,        // Serial data to device
    output logic hold_n_out,    // Pause, active low
    input wire logic so_in,     // Serial data from device
    input wire logic so_oe_in   // Device drives so
);
    localparam time HALF = 24ns;

    // Idle levels; the clock stands still between frames
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b0;
        si_out = 1'b0;
        hold_n_out = 1'b1;
        #1;
        cs_n_out = 1'b1;  // Clean rising select edge clears frame and output stages
    end

    // Select the device, then wait a setup time
    task automatic begin_f();
        #7;
        cs_n_out = 1'b0;
        #HALF;
    endtask

    // Deselect after a hold time and leave a long deselect gap
    task automatic end_f();
        #HALF;
        cs_n_out = 1'b1;
        si_out = ~si_out;  // Released line does not keep the last bit
        #150;
    endtask

    // Shift nbits of d, MSB first; q gathers so at each rise, oe is the AND of the enable
    task automatic xfer(input logic [7:0] d, input int nbits, output logic [7:0] q, output logic oe);
        q = 8'h00;
        oe = 1'b1;
        for (int i = 0; i < nbits; i++) begin
            si_out = d[7 - i];
            #HALF;
            sck_out = 1'b1;
            q = {q[6:0], so_in};
            oe = oe & so_oe_in;
            #HALF;
            sck_out = 1'b0;
        end
    endtask

    // Pause with the clock low, toggle the clock and data, resume with the clock low
    task automatic pause();
        #5;
        hold_n_out = 1'b0;
        #HALF;
        repeat (3) begin
            si_out = ~si_out;
            sck_out = 1'b1;
            #HALF;
            sck_out = 1'b0;
            #HALF;
        end
        hold_n_out = 1'b1;
        #HALF;
    endtask
endmodule

// >>> tb/spi_serial_nvram_access_test.sv
`timescale 1ns/1ps
module spi_serial_nvram_access_test;
    localparam int LIMIT = 40000;
    logic clk_sys, reset_n, wp_n, guard_hi, guard_lo;
    logic sck, cs_n, si, hold_n, so, so_oe, latch_flag;
    logic [7:0] shadow [int];
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;

    snva_nvram_access dut (.clk_sys_in(clk_sys), .reset_n_in(reset_n), .sck_in(sck), .cs_n_in(cs_n),
        .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n), .block_guard_hi_in(guard_hi),
        .block_guard_lo_in(guard_lo), .so_out(so), .so_oe_out(so_oe), .write_latch_flag_out(latch_flag));
    snva_spi_master u_mst (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n),
        .so_in(so), .so_oe_in(so_oe));

    // System clock and hang limit
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Range closed to writes for the current guard pins
    function automatic bit guarded(input logic [14:0] a);
        case ({guard_hi, guard_lo})
            snva_pkg::GUARD_NONE: return 1'b0;
            snva_pkg::GUARD_QTR: return a >= snva_pkg::GUARD_QTR_BASE;
            snva_pkg::GUARD_HALF: return a >= snva_pkg::GUARD_HALF_BASE;
            default: return 1'b1;
        endcase
    endfunction

    task automatic cmd(input logic [7:0] c);
        logic [7:0] q;
        logic oe;
        u_mst.begin_f();
        u_mst.xfer(c, 8, q, oe);
        u_mst.end_f();
    endtask

    task automatic open_f(input logic [7:0] op, input logic [15:0] a);
        logic [7:0] q;
        logic oe;
        u_mst.begin_f();
        u_mst.xfer(op, 8, q, oe);
        u_mst.xfer(a[15:8], 8, q, oe);
        u_mst.xfer(a[7:0], 8, q, oe);
        chk("oe during header", {7'h00, oe}, 8'h00);
    endtask

    // Write n bytes v, v+1..; brk bits in the last byte; drop lowers protect after byte 0
    task automatic wr(input logic [15:0] a, input int n, input logic [7:0] v, input bit en, input int brk,
            input bit drop);
        logic [7:0] q;
        logic oe;
        logic [14:0] p;
        bit ok;
        if (en) cmd(snva_pkg::OPC_SET_LATCH);
        chk("latch before write", {7'h00, latch_flag}, {7'h00, en});
        ok = en && wp_n;
        p = a[14:0];
        open_f(snva_pkg::OPC_WRITE, a);
        for (int i = 0; i < n; i++) begin
            if (drop && i == 1) @(posedge clk_sys) wp_n <= 1'b0;
            u_mst.xfer(8'(v + i), (i == n - 1) ? brk : 8, q, oe);
            if (ok && !guarded(p) && (i < n - 1 || brk == 8)) shadow[p] = 8'(v + i);
            p = p + snva_pkg::ADDR_STEP;
        end
        u_mst.end_f();
        chk("latch after write", {7'h00, latch_flag}, 8'h00);
        @(posedge clk_sys) wp_n <= 1'b1;
    endtask

    // Read n bytes from a while si carries a changing pattern
    task automatic rd(input logic [15:0] a, input int n);
        logic [7:0] q;
        logic oe;
        logic [14:0] p;
        p = a[14:0];
        open_f(snva_pkg::OPC_READ, a);
        for (int i = 0; i < n; i++) begin
            u_mst.xfer(8'(8'hA5 ^ i), 8, q, oe);
            chk("read byte", q, shadow[p]);
            chk("read oe", {7'h00, oe}, 8'h01);
            p = p + snva_pkg::ADDR_STEP;
        end
        u_mst.end_f();
        chk("oe after deselect", {6'h00, so_oe, so}, 8'h00);
    endtask

    // Long run across rows and over the top of memory, address top bit set
    task automatic t_wrap_run();
        wr(16'hFFFC, 8, 8'h10, 1'b1, 8, 1'b0);
        rd(16'hFFFC, 8);
        rd(16'h7FFF, 2);
    endtask

    // Unknown command keeps the latch; write without a fresh enable; a byte cut short by deselect
    task automatic t_latch_partial();
        cmd(snva_pkg::OPC_SET_LATCH);
        cmd(8'hFF);
        chk("latch after unknown command", {7'h00, latch_flag}, 8'h01);
        wr(16'h0010, 2, 8'h21, 1'b1, 8, 1'b0);
        wr(16'h0010, 1, 8'hEE, 1'b0, 8, 1'b0);
        wr(16'h0010, 2, 8'h51, 1'b1, 4, 1'b0);
        rd(16'h0010, 2);
    endtask

    // Protect pin low at select fall blocks; lowered mid-frame it does not
    task automatic t_protect();
        wr(16'h0030, 2, 8'h60, 1'b1, 8, 1'b0);
        @(posedge clk_sys) wp_n <= 1'b0;
        @(posedge clk_sys);
        wr(16'h0030, 2, 8'h70, 1'b1, 8, 1'b0);
        rd(16'h0030, 2);
        wr(16'h0030, 2, 8'h80, 1'b1, 8, 1'b1);
        rd(16'h0030, 2);
    endtask

    // Every guard setting against the quarter and half boundaries
    task automatic t_guard();
        for (int g = 0; g < 4; g++) begin
            @(posedge clk_sys) {guard_hi, guard_lo} <= 2'(g);
            repeat (10) @(posedge clk_sys);
            wr(16'h3FFF, 2, 8'(8'h40 + 8'h10 * g), 1'b1, 8, 1'b0);
            wr(16'h5FFF, 2, 8'(8'h48 + 8'h10 * g), 1'b1, 8, 1'b0);
            rd(16'h3FFF, 2);
            rd(16'h5FFF, 2);
        end
        @(posedge clk_sys) {guard_hi, guard_lo} <= 2'h0;
        repeat (10) @(posedge clk_sys);
    endtask

    // Pause in mid-byte with clock and data toggling, then finish the byte
    task automatic t_hold();
        logic [7:0] q;
        logic oe;
        cmd(snva_pkg::OPC_SET_LATCH);
        open_f(snva_pkg::OPC_WRITE, 16'h0040);
        u_mst.xfer(8'hC3, 4, q, oe);
        u_mst.pause();
        u_mst.xfer(8'h30, 4, q, oe);
        u_mst.end_f();
        shadow[15'h0040] = 8'hC3;
        rd(16'h0040, 1);
    endtask

    // Reset, then the scenarios
    initial begin
        reset_n = 1'b1;
        wp_n = 1'b1;
        guard_hi = 1'b0;
        guard_lo = 1'b0;
        @(posedge clk_sys) reset_n <= 1'b0;  // Clean falling edge clears the link toggles
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk("latch after reset", {7'h00, latch_flag}, 8'h00);
        t_wrap_run();
        t_latch_partial();
        t_protect();
        t_guard();
        t_hold();
        conclude();
    end
endmodule
